// *** common/tlum_consts.svh ***
// Constants for the two-level undervoltage monitor: offsets, fields, resets, timing
`ifndef TLUM_CONSTS_SVH
`define TLUM_CONSTS_SVH
// Widths and level count
`define TLUM_NLVL 2
`define TLUM_V_W 11
`define TLUM_D_W 14
`define TLUM_CLS_W 3
`define TLUM_MODE_W 2
`define TLUM_FSEL_W 5
// Register byte offsets
`define TLUM_CTRL_OFS 8'h00
`define TLUM_ACK_OFS 8'h04
`define TLUM_STAT_OFS 8'h08
`define TLUM_CODE_OFS 8'h0c
`define TLUM_LVL_BASE 8'h10
`define TLUM_LVL_STRIDE 8'h10
`define TLUM_LIM_SUB 8'h00
`define TLUM_DLY_SUB 8'h04
`define TLUM_CFG_SUB 8'h08
// Field positions
`define TLUM_CTRL_MON_BIT 0
`define TLUM_CFG_CLS_LSB 0
`define TLUM_CFG_SACK_BIT 4
`define TLUM_CFG_MODE_LSB 8
`define TLUM_CFG_FLAG_LSB 16
`define TLUM_STAT_VOLT_LSB 16
// Reset values and setting ranges, voltages in 0.1 % of rated
`define TLUM_MON_RST 1'b1
`define TLUM_SACK_RST 1'b1
`define TLUM_LIM1_RST 11'h398
`define TLUM_LIM2_RST 11'h384
`define TLUM_LIM_MIN 11'h064
`define TLUM_LIM_MAX 11'h5dc
`define TLUM_DLY1_RST 14'h0096
`define TLUM_DLY2_RST 14'h0006
`define TLUM_DLY_MAX 14'h270f
`define TLUM_HYST_DEF 10
`define TLUM_FUNC_CODE 8'h1b
// Timing: clock period in ps, tick and reset delay in ms
`define TLUM_CLK_PS 5000
`define TLUM_TICK_MS 10
`define TLUM_RST_DLY_MS 80
`define TLUM_RST_TICKS ((`TLUM_RST_DLY_MS + `TLUM_TICK_MS - 1) / `TLUM_TICK_MS)
`define TLUM_TICK_CYCLES ((64'(`TLUM_TICK_MS) * 64'h3b9a_ca00) / 64'(`TLUM_CLK_PS))
`endif

// *** common/tlum_pkg.sv ***
// Types shared by the undervoltage monitor modules
package tlum_pkg;
  `include "tlum_consts.svh"

  typedef enum logic [`TLUM_CLS_W-1:0] {
    TLUM_CLS_A, TLUM_CLS_B, TLUM_CLS_C, TLUM_CLS_D, TLUM_CLS_E, TLUM_CLS_F, TLUM_CLS_CTRL
  } tlum_class_t;

  typedef enum logic [`TLUM_MODE_W-1:0] {
    TLUM_EN_ALWAYS, TLUM_EN_LOCK, TLUM_EN_FLAG
  } tlum_en_mode_t;

  typedef enum logic [1:0] {
    TLUM_ST_IDLE, TLUM_ST_PICKUP, TLUM_ST_TRIP, TLUM_ST_RECOVER
  } tlum_lvl_state_t;

  // Settings of one level
  typedef struct packed {
    logic [`TLUM_V_W-1:0] limit;
    logic [`TLUM_D_W-1:0] delay;
    tlum_class_t cls;
    logic self_ack;
    tlum_en_mode_t en_mode;
    logic [`TLUM_FSEL_W-1:0] flag_sel;
  } tlum_cfg_t;

  // State shown by one level
  typedef struct packed {
    logic alarm;
    logic cond;
    logic pickup;
    logic trip;
    tlum_class_t cls;
  } tlum_stat_t;
endpackage

// *** design/tlum_level.sv ***
// One undervoltage supervision level: pickup timer, reset delay and alarm latch
`timescale 1ns/1ps
`include "tlum_consts.svh"
module tlum_level #(
  parameter int HYST = `TLUM_HYST_DEF,
  parameter int RST_TICKS = `TLUM_RST_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic active,
  input wire logic ack,
  input wire logic [`TLUM_V_W-1:0] volt,
  input wire tlum_pkg::tlum_cfg_t cfg,
  output tlum_pkg::tlum_stat_t stat
);
  localparam int VW1 = `TLUM_V_W + 1;

  tlum_pkg::tlum_lvl_state_t state;
  tlum_pkg::tlum_lvl_state_t next_state;
  logic [`TLUM_D_W-1:0] cnt;
  logic [`TLUM_D_W-1:0] next_cnt;
  logic alarm;
  logic trip;
  tlum_pkg::tlum_class_t cls;

  // Comparisons against the limit, recovery needs the hysteresis margin
  wire below = volt <= cfg.limit;
  wire recov = {1'b0, volt} > ({1'b0, cfg.limit} + VW1'(HYST));
  wire cond = (state == tlum_pkg::TLUM_ST_TRIP) || (state == tlum_pkg::TLUM_ST_RECOVER);
  wire set_evt = (next_state == tlum_pkg::TLUM_ST_TRIP) && !cond;

  // Definite-time pickup and recovery sequence, stepped once per tick
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (!active) begin
      next_state = tlum_pkg::TLUM_ST_IDLE;
      next_cnt = '0;
    end else if (tick) begin
      case (state)
        tlum_pkg::TLUM_ST_IDLE, tlum_pkg::TLUM_ST_PICKUP: begin
          if (state == tlum_pkg::TLUM_ST_PICKUP && recov) begin
            next_state = tlum_pkg::TLUM_ST_IDLE;
            next_cnt = '0;
          end else if (below && cnt >= cfg.delay) begin
            next_state = tlum_pkg::TLUM_ST_TRIP;
            next_cnt = '0;
          end else if (below) begin
            next_state = tlum_pkg::TLUM_ST_PICKUP;
            next_cnt = cnt + 1'b1;
          end
        end
        tlum_pkg::TLUM_ST_TRIP: begin
          if (recov) begin
            next_state = tlum_pkg::TLUM_ST_RECOVER;
            next_cnt = `TLUM_D_W'(1);
          end
        end
        tlum_pkg::TLUM_ST_RECOVER: begin
          if (!recov) begin
            next_state = tlum_pkg::TLUM_ST_TRIP;
            next_cnt = '0;
          end else if (cnt >= `TLUM_D_W'(RST_TICKS - 1)) begin
            next_state = tlum_pkg::TLUM_ST_IDLE;
            next_cnt = '0;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
        default: begin
          next_state = tlum_pkg::TLUM_ST_IDLE;
          next_cnt = '0;
        end
      endcase
    end
  end

  // State and timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= tlum_pkg::TLUM_ST_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Alarm latch: a new trip wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm <= 1'b0;
      trip <= 1'b0;
      cls <= tlum_pkg::TLUM_CLS_A;
    end else begin
      trip <= set_evt;
      if (set_evt) begin
        alarm <= 1'b1;
        cls <= cfg.cls;
      end else if (!cond && (cfg.self_ack || ack)) begin
        alarm <= 1'b0;
      end
    end
  end

  // Status outputs
  assign stat.alarm = alarm;
  assign stat.cond = cond;
  assign stat.pickup = state == tlum_pkg::TLUM_ST_PICKUP;
  assign stat.trip = trip;
  assign stat.cls = cls;
endmodule

// *** design/tlum_top.sv ***
// Two-level undervoltage monitor with APB register access
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "tlum_consts.svh"
module tlum_top #(
  parameter int TICK_CYCLES = int'(`TLUM_TICK_CYCLES),
  parameter int HYST = `TLUM_HYST_DEF,
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`TLUM_V_W-1:0] volt_pct,
  input wire logic lock_monitoring,
  input wire logic [31:0] logic_gate_flag,
  input wire logic ext_ack,
  output logic [`TLUM_NLVL-1:0] cmd_flag,
  output tlum_pkg::tlum_stat_t [`TLUM_NLVL-1:0] lvl_stat
);
  localparam int NLVL = `TLUM_NLVL;
  localparam int RST_TICKS = `TLUM_RST_TICKS;
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int VW1 = `TLUM_V_W + 1;
  localparam logic [7:0] undervoltage_function_code = `TLUM_FUNC_CODE;
  localparam tlum_pkg::tlum_cfg_t CFG_RST [NLVL] = '{
    '{limit: `TLUM_LIM1_RST, delay: `TLUM_DLY1_RST, cls: tlum_pkg::TLUM_CLS_A,
      self_ack: `TLUM_SACK_RST, en_mode: tlum_pkg::TLUM_EN_ALWAYS, flag_sel: '0},
    '{limit: `TLUM_LIM2_RST, delay: `TLUM_DLY2_RST, cls: tlum_pkg::TLUM_CLS_B,
      self_ack: `TLUM_SACK_RST, en_mode: tlum_pkg::TLUM_EN_ALWAYS, flag_sel: '0}
  };

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Address match for a register of one level
  function automatic logic lvl_hit(input logic [AW-1:0] a, input int idx, input int sub);
    lvl_hit = a == AW'(`TLUM_LVL_BASE + idx * `TLUM_LVL_STRIDE + sub);
  endfunction

  // Enable mode selection of one level
  function automatic logic gate_on(input tlum_pkg::tlum_cfg_t c, input logic lock,
                                   input logic [31:0] flags);
    case (c.en_mode)
      tlum_pkg::TLUM_EN_ALWAYS: gate_on = 1'b1;
      tlum_pkg::TLUM_EN_LOCK: gate_on = !lock;
      tlum_pkg::TLUM_EN_FLAG: gate_on = flags[c.flag_sel];
      default: gate_on = 1'b0;
    endcase
  endfunction

  // Limit written by software is held inside the settable range
  function automatic logic [`TLUM_V_W-1:0] clamp_lim(input logic [15:0] v);
    if (v < 16'(`TLUM_LIM_MIN)) begin
      clamp_lim = `TLUM_LIM_MIN;
    end else if (v > 16'(`TLUM_LIM_MAX)) begin
      clamp_lim = `TLUM_LIM_MAX;
    end else begin
      clamp_lim = v[`TLUM_V_W-1:0];
    end
  endfunction

  // Delay written by software is held at or below its maximum
  function automatic logic [`TLUM_D_W-1:0] clamp_dly(input logic [15:0] v);
    if (v > 16'(`TLUM_DLY_MAX)) begin
      clamp_dly = `TLUM_DLY_MAX;
    end else begin
      clamp_dly = v[`TLUM_D_W-1:0];
    end
  endfunction

  // Settings word of one level as read back
  function automatic logic [31:0] cfg_word(input tlum_pkg::tlum_cfg_t c);
    cfg_word = '0;
    cfg_word[`TLUM_CFG_CLS_LSB +: `TLUM_CLS_W] = c.cls;
    cfg_word[`TLUM_CFG_SACK_BIT] = c.self_ack;
    cfg_word[`TLUM_CFG_MODE_LSB +: `TLUM_MODE_W] = c.en_mode;
    cfg_word[`TLUM_CFG_FLAG_LSB +: `TLUM_FSEL_W] = c.flag_sel;
  endfunction

  logic ctrl_mon;
  tlum_pkg::tlum_cfg_t cfg [NLVL];
  logic [TW-1:0] tick_cnt;
  logic tick;
  logic ext_ack_m;
  logic ext_ack_s;
  logic [31:0] next_rdata;
  logic [31:0] stat_word;
  logic [31:0] lvl_rdata;
  logic [NLVL-1:0] hit_lim;
  logic [NLVL-1:0] hit_dly;
  logic [NLVL-1:0] hit_cfg;
  logic [NLVL-1:0] act;
  logic [NLVL-1:0] ack;
  logic [31:0] lvl_rd [NLVL];

  // Bus decode, zero wait state slave
  wire wr_en = psel && penable && pwrite;
  wire hit_ctrl = paddr == AW'(`TLUM_CTRL_OFS);
  wire hit_ack = paddr == AW'(`TLUM_ACK_OFS);
  wire hit_stat = paddr == AW'(`TLUM_STAT_OFS);
  wire hit_code = paddr == AW'(`TLUM_CODE_OFS);
  wire mapped = hit_ctrl || hit_ack || hit_stat || hit_code || (|hit_lim) ||
                (|hit_dly) || (|hit_cfg);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Tick of 10 ms that paces both level timers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == TW'(TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  // External acknowledge pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ack_m <= 1'b0;
      ext_ack_s <= 1'b0;
    end else begin
      ext_ack_m <= ext_ack;
      ext_ack_s <= ext_ack_m;
    end
  end

  // Monitoring on/off control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_mon <= `TLUM_MON_RST;
    end else if (wr_en && hit_ctrl) begin
      ctrl_mon <= pwdata[`TLUM_CTRL_MON_BIT];
    end
  end

  // Status word: alarms, conditions, pickups and the measured voltage
  always_comb begin
    stat_word = '0;
    for (int i = 0; i < NLVL; i++) begin
      stat_word[i] = lvl_stat[i].alarm;
      stat_word[NLVL + i] = lvl_stat[i].cond;
      stat_word[2 * NLVL + i] = lvl_stat[i].pickup;
    end
    stat_word[`TLUM_STAT_VOLT_LSB +: `TLUM_V_W] = volt_pct;
  end

  // Read data selection
  always_comb begin
    lvl_rdata = '0;
    for (int i = 0; i < NLVL; i++) begin
      if (hit_lim[i] || hit_dly[i] || hit_cfg[i]) begin
        lvl_rdata = lvl_rd[i];
      end
    end
    if (hit_ctrl) begin
      next_rdata = 32'(ctrl_mon);
    end else if (hit_stat) begin
      next_rdata = stat_word;
    end else if (hit_code) begin
      next_rdata = 32'(undervoltage_function_code);
    end else begin
      next_rdata = lvl_rdata;
    end
  end

  // Read data are captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= next_rdata;
    end
  end

  // Two identical supervision levels
  for (genvar g = 0; g < NLVL; g++) begin : g_lvl
    logic [`TLUM_D_W:0] hcnt;
    logic [3:0] rcnt;

    assign hit_lim[g] = lvl_hit(paddr, g, `TLUM_LIM_SUB);
    assign hit_dly[g] = lvl_hit(paddr, g, `TLUM_DLY_SUB);
    assign hit_cfg[g] = lvl_hit(paddr, g, `TLUM_CFG_SUB);
    assign lvl_rd[g] = hit_lim[g] ? 32'(cfg[g].limit) :
                       hit_dly[g] ? 32'(cfg[g].delay) : cfg_word(cfg[g]);
    assign act[g] = ctrl_mon && gate_on(cfg[g], lock_monitoring, logic_gate_flag);
    assign ack[g] = ext_ack_s || (wr_en && hit_ack && pwdata[g]);
    assign cmd_flag[g] = lvl_stat[g].alarm;

    // Settings of this level; invalid class or mode codes are ignored
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg[g] <= CFG_RST[g];
      end else if (wr_en && hit_lim[g]) begin
        cfg[g].limit <= clamp_lim(pwdata[15:0]);
      end else if (wr_en && hit_dly[g]) begin
        cfg[g].delay <= clamp_dly(pwdata[15:0]);
      end else if (wr_en && hit_cfg[g]) begin
        if (pwdata[`TLUM_CFG_CLS_LSB +: `TLUM_CLS_W] <= tlum_pkg::TLUM_CLS_CTRL) begin
          cfg[g].cls <= tlum_pkg::tlum_class_t'(pwdata[`TLUM_CFG_CLS_LSB +: `TLUM_CLS_W]);
        end
        if (pwdata[`TLUM_CFG_MODE_LSB +: `TLUM_MODE_W] <= tlum_pkg::TLUM_EN_FLAG) begin
          cfg[g].en_mode <= tlum_pkg::tlum_en_mode_t'(pwdata[`TLUM_CFG_MODE_LSB +: `TLUM_MODE_W]);
        end
        cfg[g].self_ack <= pwdata[`TLUM_CFG_SACK_BIT];
        cfg[g].flag_sel <= pwdata[`TLUM_CFG_FLAG_LSB +: `TLUM_FSEL_W];
      end
    end

    tlum_level #(
      .HYST(HYST),
      .RST_TICKS(RST_TICKS)
    ) u_level (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .active(act[g]),
      .ack(ack[g]),
      .volt(volt_pct),
      .cfg(cfg[g]),
      .stat(lvl_stat[g])
    );

    // Check helpers: ticks spent in pickup and ticks of recovered voltage
    wire recov_h = {1'b0, volt_pct} > ({1'b0, cfg[g].limit} + VW1'(HYST));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hcnt <= '0;
        rcnt <= '0;
      end else begin
        hcnt <= !lvl_stat[g].pickup ? '0 : hcnt + (tick && hcnt != '1);
        rcnt <= !lvl_stat[g].cond ? '0 : tick ? (recov_h ? rcnt + 1'b1 : '0) : rcnt;
      end
    end

    sequence s_pickup_end;
      $rose(lvl_stat[g].cond) ##0 $past(lvl_stat[g].pickup);
    endsequence
    sequence s_recovered_clear;
      $fell(lvl_stat[g].cond) ##0 $past(act[g]);
    endsequence

    chk_flag_on_trip: assert property (lvl_stat[g].trip |-> cmd_flag[g])
      else $error("command flag not raised with trip");
    chk_class_captured: assert property (
      lvl_stat[g].trip |-> lvl_stat[g].cls == $past(cfg[g].cls) && lvl_stat[g].cond)
      else $error("alarm class not taken from settings at trip");
    chk_delay_elapsed: assert property (
      s_pickup_end |-> hcnt >= ($past(cfg[g].delay) + 1'b0))
      else $error("trip before the configured delay");
    chk_trip_needs_tick: assert property ($rose(lvl_stat[g].cond) |-> $past(tick))
      else $error("trip outside a tick");
    chk_reset_delay: assert property (s_recovered_clear |-> rcnt == 4'(RST_TICKS))
      else $error("condition cleared without the full reset delay");
    chk_hyst_restart: assert property (
      tick && act[g] && lvl_stat[g].pickup && recov_h |=> !lvl_stat[g].pickup && !lvl_stat[g].cond)
      else $error("timer not cleared on recovery");
    chk_mon_off_idle: assert property (!ctrl_mon |=> !lvl_stat[g].pickup && !lvl_stat[g].cond)
      else $error("level active while monitoring is off");
    chk_limit_range: assert property (
      cfg[g].limit >= `TLUM_LIM_MIN && cfg[g].limit <= `TLUM_LIM_MAX &&
      cfg[g].delay <= `TLUM_DLY_MAX)
      else $error("setting outside its range");
    chk_self_ack_clear: assert property (
      lvl_stat[g].alarm && !lvl_stat[g].cond && cfg[g].self_ack
      |=> !lvl_stat[g].alarm || lvl_stat[g].cond)
      else $error("self acknowledged alarm did not clear");
    chk_latch_hold: assert property (
      lvl_stat[g].alarm && !cfg[g].self_ack && !ack[g] |=> lvl_stat[g].alarm)
      else $error("latched alarm cleared without acknowledge");
    chk_always_runs: assert property (
      ctrl_mon && cfg[g].en_mode == tlum_pkg::TLUM_EN_ALWAYS && tick &&
      volt_pct <= cfg[g].limit |=> lvl_stat[g].pickup || lvl_stat[g].cond)
      else $error("always enabled level did not run");
    chk_lock_stops: assert property (
      cfg[g].en_mode == tlum_pkg::TLUM_EN_LOCK && lock_monitoring
      |=> !lvl_stat[g].pickup && !lvl_stat[g].cond)
      else $error("level ran while locked");
    chk_flag_gate: assert property (
      cfg[g].en_mode == tlum_pkg::TLUM_EN_FLAG && !logic_gate_flag[cfg[g].flag_sel]
      |=> !lvl_stat[g].pickup && !lvl_stat[g].cond)
      else $error("level ran with its flag false");
  end
endmodule

// *** sim/tlum_front.sv ***
// Measurement front end and external acknowledge source facing the monitor
`timescale 1ns/1ps
`include "tlum_consts.svh"
module tlum_front #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`TLUM_V_W-1:0] volt_req,
  input wire logic ack_req,
  output logic [`TLUM_V_W-1:0] volt_pct,
  output logic ext_ack
);
  int cnt;

  // Reading in 0.1 % of rated, refreshed once per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      volt_pct <= 11'h3e8;
    end else begin
      cnt <= (cnt == TICK_CYCLES - 1) ? 0 : cnt + 1;
      if (cnt == 0) begin
        volt_pct <= volt_req;
      end
    end
  end

  // Acknowledge contact follows the request one clock later, for as long as it is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ack <= 1'b0;
    end else begin
      ext_ack <= ack_req;
    end
  end
endmodule

// *** sim/tlum_top_tb_top.sv ***
// Self-checking bench for the two-level undervoltage monitor
`timescale 1ns/1ps
`include "tlum_consts.svh"
module tlum_top_tb_top;
  localparam int TK = 20;
  typedef struct {
    logic lvl;
    logic [10:0] lim;
    logic [13:0] dly;
    logic [2:0] cls;
    logic [10:0] v;
    logic trip;
  } tlum_row_t;
  tlum_row_t rows [7] = '{
    '{1'h0, 11'h1f4, 14'h0002, 3'h0, 11'h1f4, 1'h1},
    '{1'h1, 11'h1f4, 14'h0002, 3'h2, 11'h064, 1'h1},
    '{1'h0, 11'h1f4, 14'h0003, 3'h3, 11'h1f5, 1'h0},
    '{1'h1, 11'h5dc, 14'h0000, 3'h4, 11'h578, 1'h1},
    '{1'h0, 11'h064, 14'h0001, 3'h5, 11'h064, 1'h1},
    '{1'h1, 11'h320, 14'h0002, 3'h6, 11'h31f, 1'h1},
    '{1'h0, 11'h320, 14'h0002, 3'h1, 11'h384, 1'h0}};
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28};
  logic [31:0] rv [9] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_001b, 32'h0000_0398,
    32'h0000_0096, 32'h0000_0010, 32'h0000_0384, 32'h0000_0006, 32'h0000_0011};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [`TLUM_V_W-1:0] volt_pct;
  logic [`TLUM_V_W-1:0] vreq = 11'h3e8;
  logic ack_req = 1'b0;
  logic ext_ack;
  logic lock = 1'b0;
  logic [31:0] flags = 32'h0000_0000;
  logic [`TLUM_NLVL-1:0] cmd_flag;
  tlum_pkg::tlum_stat_t [`TLUM_NLVL-1:0] lvl_stat;
  logic [31:0] rdv;
  logic errv;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;

  // Device, front end and clock
  tlum_top #(.TICK_CYCLES(TK), .HYST(10), .AW(8)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .volt_pct(volt_pct),
    .lock_monitoring(lock), .logic_gate_flag(flags), .ext_ack(ext_ack),
    .cmd_flag(cmd_flag), .lvl_stat(lvl_stat));
  tlum_front #(.TICK_CYCLES(TK)) front (.pclk(pclk), .presetn(presetn), .volt_req(vreq),
    .ack_req(ack_req), .volt_pct(volt_pct), .ext_ack(ext_ack));
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h got %h", nm, e, g);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg_lvl(input logic l, input logic [10:0] lim, input logic [13:0] dly,
    input logic [2:0] cls, input logic sack, input logic [1:0] md, input logic [4:0] fs);
    logic [7:0] b;
    b = l ? 8'h20 : 8'h10;
    apb(1'b1, b, 32'(lim));
    apb(1'b1, b + 8'h04, 32'(dly));
    apb(1'b1, b + 8'h08, {11'h000, fs, 6'h00, md, 3'h0, sack, 1'h0, cls});
  endtask

  task automatic wait_cmd(input logic l, input logic v, input int n);
    for (int k = 0; k < n && cmd_flag[l] !== v; k++) @(posedge pclk);
  endtask

  // Level 2 dip, then its flag is compared
  task automatic dip(input logic e, input int n);
    vreq <= 11'h352;
    repeat (n * TK) @(posedge pclk);
    chk("dip_cmd", 32'(e), 32'(cmd_flag[1]));
  endtask

  task automatic rise();
    vreq <= 11'h3e8;
    wait_cmd(1'h1, 1'h0, 10 * TK);
    chk("rise_cmd", 32'h0000_0000, 32'(cmd_flag));
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      cfg_lvl(rows[i].lvl, rows[i].lim, rows[i].dly, rows[i].cls, 1'h1, 2'h0, 5'h00);
      cfg_lvl(!rows[i].lvl, 11'h398, 14'h0006, 3'h0, 1'h1, 2'h2, 5'h05);
      vreq <= rows[i].v;
      repeat (int'(rows[i].dly) * TK) @(posedge pclk);
      chk("early", 32'h0000_0000, 32'(cmd_flag));
      wait_cmd(rows[i].lvl, 1'h1, 2 * TK + 4);
      chk("trip", 32'(2'(rows[i].trip) << rows[i].lvl), 32'(cmd_flag));
      if (rows[i].trip) begin
        chk("class", 32'(rows[i].cls), 32'(lvl_stat[rows[i].lvl].cls));
      end
      vreq <= 11'h60e;
      repeat (7 * TK) @(posedge pclk);
      chk("hold", 32'(2'(rows[i].trip) << rows[i].lvl), 32'(cmd_flag));
      wait_cmd(rows[i].lvl, 1'h0, 2 * TK + 4);
      chk("clear", 32'h0000_0000, 32'(cmd_flag));
    end
    cfg_lvl(1'h1, 11'h384, 14'h0006, 3'h1, 1'h1, 2'h0, 5'h00);
    dip(1'h1, 9);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("rst_cmd", 32'h0000_0000, 32'(cmd_flag));
    chk("rst_rd", 32'h0000_0000, prdata);
    vreq <= 11'h3e8;
    @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ra[i], 32'h0000_0000);
      chk("reg_rst", rv[i], rdv);
    end
    vreq <= 11'h352;
    wait_cmd(1'h1, 1'h1, 9 * TK);
    chk("l2_cmd", 32'h0000_0002, 32'(cmd_flag));
    chk("l2_cls", 32'h0000_0001, 32'(lvl_stat[1].cls));
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("stat", 32'h0352_001a, rdv);
    repeat (140 * TK) @(posedge pclk);
    chk("l1_early", 32'h0000_0000, 32'(cmd_flag[0]));
    wait_cmd(1'h0, 1'h1, 12 * TK);
    chk("l1_cmd", 32'h0000_0003, 32'(cmd_flag));
    chk("l1_cls", 32'h0000_0000, 32'(lvl_stat[0].cls));
    vreq <= 11'h3e8;
    wait_cmd(1'h0, 1'h0, 10 * TK);
    chk("both_clr", 32'h0000_0000, 32'(cmd_flag));
    apb(1'b1, 8'h10, 32'h0000_0032);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("lim_lo", 32'h0000_0064, rdv);
    apb(1'b1, 8'h10, 32'h0000_07ff);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("lim_hi", 32'h0000_05dc, rdv);
    apb(1'b1, 8'h14, 32'h0000_ffff);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("dly_hi", 32'h0000_270f, rdv);
    apb(1'b1, 8'h28, 32'h0000_0317);
    apb(1'b0, 8'h28, 32'h0000_0000);
    chk("cfg_bad", 32'h0000_0011, rdv);
    apb(1'b0, 8'h3c, 32'h0000_0000);
    chk("unmap", 32'h0000_0001, 32'(errv));
    chk("pready", 32'h0000_0001, 32'(pready));
    cfg_lvl(1'h0, 11'h398, 14'h0096, 3'h0, 1'h1, 2'h2, 5'h1f);
    vreq <= 11'h352;
    repeat (4 * TK) @(posedge pclk);
    vreq <= 11'h3e8;
    repeat (2 * TK) @(posedge pclk);
    dip(1'h0, 5);
    wait_cmd(1'h1, 1'h1, 4 * TK);
    chk("re_trip", 32'h0000_0002, 32'(cmd_flag));
    rise();
    cfg_lvl(1'h1, 11'h384, 14'h0006, 3'h1, 1'h0, 2'h0, 5'h00);
    dip(1'h1, 9);
    apb(1'b1, 8'h04, 32'h0000_0002);
    chk("ack_early", 32'h0000_0002, 32'(cmd_flag));
    vreq <= 11'h3e8;
    repeat (11 * TK) @(posedge pclk);
    chk("latched", 32'h0000_0002, 32'(cmd_flag));
    apb(1'b1, 8'h04, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk("ack_reg", 32'h0000_0000, 32'(cmd_flag));
    dip(1'h1, 9);
    vreq <= 11'h3e8;
    repeat (11 * TK) @(posedge pclk);
    ack_req <= 1'b1;
    @(posedge pclk);
    ack_req <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("ack_pin", 32'h0000_0000, 32'(cmd_flag));
    cfg_lvl(1'h1, 11'h384, 14'h0006, 3'h1, 1'h1, 2'h0, 5'h00);
    apb(1'b1, 8'h00, 32'h0000_0000);
    dip(1'h0, 10);
    apb(1'b1, 8'h00, 32'h0000_0001);
    dip(1'h1, 9);
    rise();
    cfg_lvl(1'h1, 11'h384, 14'h0006, 3'h1, 1'h1, 2'h1, 5'h00);
    lock <= 1'b1;
    dip(1'h0, 10);
    lock <= 1'b0;
    dip(1'h1, 9);
    rise();
    cfg_lvl(1'h1, 11'h384, 14'h0006, 3'h1, 1'h1, 2'h2, 5'h05);
    flags <= 32'h0000_0020;
    dip(1'h1, 9);
    flags <= 32'h0000_0000;
    rise();
    finish_test();
  end
endmodule
